//--- det_pkg.sv
// constants, types and helpers for the dual 8-bit interval and event timer
// Function
// [RULE_01] mode register runs counters; resets 00H
// [RULE_02] software changes mode only while stopped
// [RULE_03] cascaded pair started/stopped by first enable only
// [RULE_04] output control register, resets to 00H
// [RULE_05] drive enable picks port latch or flop
// [RULE_06] toggle enable gates flop inversion on match
// [RULE_07] set/clear pair: keep, force 0, force 1
// [RULE_08] set and clear bits always read zero
// [RULE_09] output control written only while stopped
// [RULE_10] software clears direction and latch bits first
// [RULE_11] port direction per pin, resets FFH
// [RULE_12] match clears counter, keeps counting, interrupts
// [RULE_13] clock select low nibble one, high two
// [RULE_14] event mode counts own input pin
// [RULE_15] event mode counts rising or falling edge
// [RULE_16] enabled toggle gives square wave on match
// [RULE_17] cascade bit chains overflow into counter two
// [RULE_18] bit 0 enables the cascaded pair
// [RULE_19] interval is compare plus one count periods
// [RULE_20] unlisted clock select codes never count
`default_nettype none
package det_pkg;

	localparam int unsigned DATA_W        = 32;
	localparam int unsigned PRE_W         = 11;

	// register indices, byte address is four times the index
	localparam logic [15:0] IDX_CLK_SEL   = 16'hff41;
	localparam logic [15:0] IDX_OUT_CTL   = 16'hff4f;
	localparam logic [15:0] IDX_MODE      = 16'hff49;
	localparam logic [15:0] IDX_P3_DIR    = 16'hff23;
	localparam logic [15:0] IDX_P3_LATCH  = 16'hff03;
	localparam logic [15:0] IDX_CMP_ONE   = 16'hff4a;
	localparam logic [15:0] IDX_CMP_TWO   = 16'hff4b;
	localparam logic [15:0] IDX_CNT_ONE   = 16'hff4c;
	localparam logic [15:0] IDX_CNT_TWO   = 16'hff4d;

	// mode control fields
	localparam int unsigned MODE_RUN_ONE  = 0;
	localparam int unsigned MODE_RUN_TWO  = 1;
	localparam int unsigned MODE_CASCADE  = 2;
	localparam logic [7:0]  MODE_MASK     = 8'h07;

	// output control fields
	localparam int unsigned OUT_OE_ONE    = 0;
	localparam int unsigned OUT_TOG_ONE   = 1;
	localparam int unsigned OUT_CLR_ONE   = 2;
	localparam int unsigned OUT_SET_ONE   = 3;
	localparam int unsigned OUT_OE_TWO    = 4;
	localparam int unsigned OUT_TOG_TWO   = 5;
	localparam int unsigned OUT_CLR_TWO   = 6;
	localparam int unsigned OUT_SET_TWO   = 7;
	localparam logic [7:0]  OUT_KEEP_MASK = 8'h33;

	// clock select field positions
	localparam int unsigned CS_ONE_LSB    = 0;
	localparam int unsigned CS_TWO_LSB    = 4;

	// port 3 pin positions
	localparam int unsigned PIN_WAVE_ONE  = 1;
	localparam int unsigned PIN_WAVE_TWO  = 2;
	localparam int unsigned PIN_EVT_ONE   = 3;
	localparam int unsigned PIN_EVT_TWO   = 4;

	// reset values
	localparam logic [7:0]  RST_MODE      = 8'h00;
	localparam logic [7:0]  RST_OUT_CTL   = 8'h00;
	localparam logic [7:0]  RST_P3_DIR    = 8'hff;
	localparam logic [7:0]  RST_P3_LATCH  = 8'h00;
	localparam logic [7:0]  RST_CLK_SEL   = 8'h00;
	localparam logic [7:0]  RST_CMP       = 8'h00;
	localparam logic [7:0]  RST_CNT       = 8'h00;

	// count clock select codes
	localparam logic [3:0]  CS_FALL       = 4'h0;
	localparam logic [3:0]  CS_RISE       = 4'h1;
	localparam logic [3:0]  CS_DIV2       = 4'h6;
	localparam logic [3:0]  CS_DIV4       = 4'h7;
	localparam logic [3:0]  CS_DIV8       = 4'h8;
	localparam logic [3:0]  CS_DIV16      = 4'h9;
	localparam logic [3:0]  CS_DIV32      = 4'ha;
	localparam logic [3:0]  CS_DIV64      = 4'hb;
	localparam logic [3:0]  CS_DIV128     = 4'hc;
	localparam logic [3:0]  CS_DIV256     = 4'hd;
	localparam logic [3:0]  CS_DIV512     = 4'he;
	localparam logic [3:0]  CS_DIV2048    = 4'hf;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} det_bus_e;

	typedef struct packed {
		logic run;
		logic inc;
		logic self_clr;
		logic force_clr;
		logic ff_set;
		logic ff_clr;
		logic toggle;
	} det_chan_ctl_s;

	typedef struct packed {
		logic [7:0] count;
		logic       equal;
		logic       wrap;
		logic       flop;
	} det_chan_sts_s;

	function automatic logic [31:0] det_addr(input logic [15:0] idx);
		det_addr = {14'h0000, idx, 2'b00};
	endfunction

	// one count pulse for the selected source
	function automatic logic det_count_pulse(input logic [3:0] sel, input logic [PRE_W-1:0] pre,
		input logic rise, input logic fall);
		case (sel)
			CS_FALL:    det_count_pulse = fall;
			CS_RISE:    det_count_pulse = rise;
			CS_DIV2:    det_count_pulse = pre[0];
			CS_DIV4:    det_count_pulse = &pre[1:0];
			CS_DIV8:    det_count_pulse = &pre[2:0];
			CS_DIV16:   det_count_pulse = &pre[3:0];
			CS_DIV32:   det_count_pulse = &pre[4:0];
			CS_DIV64:   det_count_pulse = &pre[5:0];
			CS_DIV128:  det_count_pulse = &pre[6:0];
			CS_DIV256:  det_count_pulse = &pre[7:0];
			CS_DIV512:  det_count_pulse = &pre[8:0];
			CS_DIV2048: det_count_pulse = &pre[10:0];
			default:    det_count_pulse = 1'b0;
		endcase
	endfunction

endpackage
`default_nettype wire

//--- det_prescaler.sv
// free-running divider for the internal count clocks
`timescale 1ns/10ps
`default_nettype none
module det_prescaler
	import det_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	output var  logic [PRE_W-1:0] pre_q
);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_q <= '0;
		else
			pre_q <= pre_q + 1'b1;
	end

endmodule
`default_nettype wire

//--- det_channel.sv
// one 8-bit counter with compare and output flop
`timescale 1ns/10ps
`default_nettype none
module det_channel
	import det_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire det_chan_ctl_s ctl,
	input  wire logic [7:0]    cmp,
	output var  det_chan_sts_s sts
);

	logic [7:0] count_q;
	logic       flop_q;
	logic       step;
	logic       equal;

	assign step  = ctl.run & ctl.inc;
	assign equal = (count_q == cmp);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_q <= RST_CNT;
		else if (ctl.force_clr)
			count_q <= '0;
		else if (step && ctl.self_clr && equal)
			count_q <= '0; // [RULE_12] [RULE_19]
		else if (step)
			count_q <= count_q + 8'h01;
	end

	// forced levels win over a toggle in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flop_q <= 1'b0;
		else if (ctl.ff_set)
			flop_q <= 1'b1; // [RULE_07]
		else if (ctl.ff_clr)
			flop_q <= 1'b0; // [RULE_07]
		else if (ctl.toggle)
			flop_q <= ~flop_q; // [RULE_16]
	end

	always_comb
	begin
		sts.count = count_q;
		sts.equal = equal;
		sts.wrap  = step & (count_q == 8'hff) & ~ctl.force_clr & ~(ctl.self_clr & equal); // [RULE_17]
		sts.flop  = flop_q;
	end

endmodule
`default_nettype wire

//--- det_timer.sv
// dual 8-bit interval and event timer with apb register access
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module det_timer
	import det_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output var  logic [DATA_W-1:0] prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic [7:0]        p3_in,
	output var  logic [7:0]        p3_out,
	output var  logic [7:0]        p3_oe,
	output var  logic              match_irq_one,
	output var  logic              match_irq_two
);

	det_bus_e          bus_q;
	logic [DATA_W-1:0] prdata_q;
	logic              pready_q;
	logic              pslverr_q;

	logic [7:0]        mode_q;
	logic [7:0]        out_ctl_q;
	logic [7:0]        p3_dir_q;
	logic [7:0]        p3_latch_q;
	logic [7:0]        clk_sel_q;
	logic [7:0]        cmp_one_q;
	logic [7:0]        cmp_two_q;

	logic [7:0]        p3_meta_q;
	logic [7:0]        p3_sync_q;
	logic [7:0]        p3_prev_q;
	logic [7:0]        p3_out_q;
	logic [7:0]        p3_oe_q;
	logic              irq_one_q;
	logic              irq_two_q;

	logic [PRE_W-1:0]  pre;
	det_chan_ctl_s     ctl_one;
	det_chan_ctl_s     ctl_two;
	det_chan_sts_s     sts_one;
	det_chan_sts_s     sts_two;

	logic              sel_mode;
	logic              sel_out;
	logic              sel_dir;
	logic              sel_latch;
	logic              sel_clk;
	logic              sel_cmp_one;
	logic              sel_cmp_two;
	logic              sel_cnt_one;
	logic              sel_cnt_two;
	logic              mapped;
	logic              wr_fire;
	logic [7:0]        rd_byte;
	logic [7:0]        p3_view;

	logic              cascade;
	logic              run_one;
	logic              run_two;
	logic              rise_one;
	logic              fall_one;
	logic              rise_two;
	logic              fall_two;
	logic              pulse_one;
	logic              pulse_two;
	logic              hit_one;
	logic              hit_two;
	logic              both_hit;
	logic              wr_out;
	logic              set_one;
	logic              clr_one;
	logic              set_two;
	logic              clr_two;
	logic [7:0]        p3_out_d;
	logic [7:0]        p3_oe_d;

	// address decode
	assign sel_mode    = (paddr == det_addr(IDX_MODE));
	assign sel_out     = (paddr == det_addr(IDX_OUT_CTL));
	assign sel_dir     = (paddr == det_addr(IDX_P3_DIR));
	assign sel_latch   = (paddr == det_addr(IDX_P3_LATCH));
	assign sel_clk     = (paddr == det_addr(IDX_CLK_SEL));
	assign sel_cmp_one = (paddr == det_addr(IDX_CMP_ONE));
	assign sel_cmp_two = (paddr == det_addr(IDX_CMP_TWO));
	assign sel_cnt_one = (paddr == det_addr(IDX_CNT_ONE));
	assign sel_cnt_two = (paddr == det_addr(IDX_CNT_TWO));
	assign mapped      = sel_mode | sel_out | sel_dir | sel_latch | sel_clk
		| sel_cmp_one | sel_cmp_two | sel_cnt_one | sel_cnt_two;

	// writes land at the edge that samples pready high
	assign wr_fire = (bus_q == BUS_ACK) & psel & penable & pwrite & mapped;

	// input pins read the synchronised level, output pins the latch
	assign p3_view = (p3_dir_q & p3_sync_q) | (~p3_dir_q & p3_latch_q);

	always_comb
	begin
		rd_byte = 8'h00;
		if (sel_mode)
			rd_byte = mode_q;
		else if (sel_out)
			rd_byte = out_ctl_q; // [RULE_08]
		else if (sel_dir)
			rd_byte = p3_dir_q;
		else if (sel_latch)
			rd_byte = p3_view;
		else if (sel_clk)
			rd_byte = clk_sel_q;
		else if (sel_cmp_one)
			rd_byte = cmp_one_q;
		else if (sel_cmp_two)
			rd_byte = cmp_two_q;
		else if (sel_cnt_one)
			rd_byte = sts_one.count;
		else if (sel_cnt_two)
			rd_byte = sts_two.count;
	end

	// bus handshake: one wait cycle, then pready for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_q     <= BUS_IDLE;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end
		else
		begin
			case (bus_q)
				BUS_IDLE:
				begin
					if (psel && penable)
					begin
						bus_q     <= BUS_ACK;
						pready_q  <= 1'b1;
						pslverr_q <= ~mapped;
						prdata_q  <= pwrite ? '0 : {24'h000000, rd_byte};
					end
				end
				BUS_ACK:
				begin
					bus_q     <= BUS_IDLE;
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
				end
				default:
				begin
					bus_q     <= BUS_IDLE;
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
				end
			endcase
		end
	end

	// mode control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= RST_MODE; // [RULE_01]
		else if (wr_fire && sel_mode)
			mode_q <= pwdata[7:0] & MODE_MASK; // [RULE_01]
	end

	// output control, set and clear bits are not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_ctl_q <= RST_OUT_CTL; // [RULE_04]
		else if (wr_out)
			out_ctl_q <= pwdata[7:0] & OUT_KEEP_MASK; // [RULE_04] [RULE_08]
	end

	// port 3 direction and latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p3_dir_q <= RST_P3_DIR; // [RULE_11]
		else if (wr_fire && sel_dir)
			p3_dir_q <= pwdata[7:0]; // [RULE_11]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p3_latch_q <= RST_P3_LATCH;
		else if (wr_fire && sel_latch)
			p3_latch_q <= pwdata[7:0];
	end

	// clock select and compare values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_sel_q <= RST_CLK_SEL;
		else if (wr_fire && sel_clk)
			clk_sel_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_one_q <= RST_CMP;
			cmp_two_q <= RST_CMP;
		end
		else
		begin
			if (wr_fire && sel_cmp_one)
				cmp_one_q <= pwdata[7:0];
			if (wr_fire && sel_cmp_two)
				cmp_two_q <= pwdata[7:0];
		end
	end

	// pin synchroniser and edge history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p3_meta_q <= 8'h00;
			p3_sync_q <= 8'h00;
			p3_prev_q <= 8'h00;
		end
		else
		begin
			p3_meta_q <= p3_in;
			p3_sync_q <= p3_meta_q;
			p3_prev_q <= p3_sync_q;
		end
	end

	assign rise_one = p3_sync_q[PIN_EVT_ONE] & ~p3_prev_q[PIN_EVT_ONE]; // [RULE_14]
	assign fall_one = ~p3_sync_q[PIN_EVT_ONE] & p3_prev_q[PIN_EVT_ONE]; // [RULE_14]
	assign rise_two = p3_sync_q[PIN_EVT_TWO] & ~p3_prev_q[PIN_EVT_TWO]; // [RULE_14]
	assign fall_two = ~p3_sync_q[PIN_EVT_TWO] & p3_prev_q[PIN_EVT_TWO]; // [RULE_14]

	// count pulse per channel, prohibited codes give none
	assign pulse_one = det_count_pulse(clk_sel_q[CS_ONE_LSB +: 4], pre, rise_one, fall_one); // [RULE_13] [RULE_15] [RULE_20]
	assign pulse_two = det_count_pulse(clk_sel_q[CS_TWO_LSB +: 4], pre, rise_two, fall_two); // [RULE_13] [RULE_15] [RULE_20]

	// run control and cascade
	assign cascade  = mode_q[MODE_CASCADE]; // [RULE_17]
	assign run_one  = mode_q[MODE_RUN_ONE];
	assign run_two  = cascade ? mode_q[MODE_RUN_ONE] : mode_q[MODE_RUN_TWO]; // [RULE_18] [RULE_03]

	// compare matches
	assign hit_one  = run_one & pulse_one & sts_one.equal; // [RULE_12]
	assign both_hit = cascade & hit_one & sts_two.equal; // [RULE_17]
	assign hit_two  = cascade ? both_hit : (run_two & pulse_two & sts_two.equal); // [RULE_12]

	// flop set and clear on output control writes, 11 changes nothing
	assign wr_out  = wr_fire & sel_out;
	assign set_one = wr_out & pwdata[OUT_SET_ONE] & ~pwdata[OUT_CLR_ONE]; // [RULE_07]
	assign clr_one = wr_out & pwdata[OUT_CLR_ONE] & ~pwdata[OUT_SET_ONE]; // [RULE_07]
	assign set_two = wr_out & pwdata[OUT_SET_TWO] & ~pwdata[OUT_CLR_TWO]; // [RULE_07]
	assign clr_two = wr_out & pwdata[OUT_CLR_TWO] & ~pwdata[OUT_SET_TWO]; // [RULE_07]

	always_comb
	begin
		ctl_one.run       = run_one;
		ctl_one.inc       = pulse_one;
		ctl_one.self_clr  = ~cascade;
		ctl_one.force_clr = both_hit;
		ctl_one.ff_set    = set_one;
		ctl_one.ff_clr    = clr_one;
		ctl_one.toggle    = hit_one & out_ctl_q[OUT_TOG_ONE]; // [RULE_06] [RULE_16]
		ctl_two.run       = run_two;
		ctl_two.inc       = cascade ? sts_one.wrap : pulse_two; // [RULE_17]
		ctl_two.self_clr  = ~cascade;
		ctl_two.force_clr = both_hit;
		ctl_two.ff_set    = set_two;
		ctl_two.ff_clr    = clr_two;
		ctl_two.toggle    = hit_two & out_ctl_q[OUT_TOG_TWO]; // [RULE_06] [RULE_16]
	end

	det_prescaler u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.pre_q   (pre)
	);

	det_channel u_chan_one (
		.pclk    (pclk),
		.presetn (presetn),
		.ctl     (ctl_one),
		.cmp     (cmp_one_q),
		.sts     (sts_one)
	);

	det_channel u_chan_two (
		.pclk    (pclk),
		.presetn (presetn),
		.ctl     (ctl_two),
		.cmp     (cmp_two_q),
		.sts     (sts_two)
	);

	// match interrupt pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_one_q <= 1'b0;
			irq_two_q <= 1'b0;
		end
		else
		begin
			irq_one_q <= hit_one; // [RULE_12]
			irq_two_q <= hit_two; // [RULE_12]
		end
	end

	// pin drive: direction bit 0 drives, timer flop replaces the latch
	always_comb
	begin
		p3_oe_d  = ~p3_dir_q;
		p3_out_d = p3_latch_q;
		if (out_ctl_q[OUT_OE_ONE])
			p3_out_d[PIN_WAVE_ONE] = sts_one.flop; // [RULE_05]
		if (out_ctl_q[OUT_OE_TWO])
			p3_out_d[PIN_WAVE_TWO] = sts_two.flop; // [RULE_05]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p3_out_q <= 8'h00;
			p3_oe_q  <= 8'h00;
		end
		else
		begin
			p3_out_q <= p3_out_d;
			p3_oe_q  <= p3_oe_d;
		end
	end

	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign p3_out        = p3_out_q;
	assign p3_oe         = p3_oe_q;
	assign match_irq_one = irq_one_q;
	assign match_irq_two = irq_two_q;

endmodule
`default_nettype wire

//--- det_timer_chk.sv
// port assertions for the dual 8-bit timer
`timescale 1ns/10ps
`default_nettype none
module det_timer_chk
	import det_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       paddr,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [7:0]        p3_out,
	input wire logic [7:0]        p3_oe,
	input wire logic              match_irq_one,
	input wire logic              match_irq_two
);
	localparam logic [31:0] A_OUT  = {14'h0000, IDX_OUT_CTL, 2'b00};
	localparam logic [31:0] A_MODE = {14'h0000, IDX_MODE, 2'b00};
	localparam logic [31:0] A_DIR  = {14'h0000, IDX_P3_DIR, 2'b00};
	logic rd_done;
	logic dir_wr;
	assign rd_done = psel && penable && pready && !pwrite;
	assign dir_wr = psel && penable && pready && pwrite && paddr == A_DIR;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rst_out;
		!$past(presetn) |-> p3_oe == 8'h00 && p3_out == 8'h00 && !match_irq_one && !match_irq_two;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not at reset level");
	property p_irq_one;
		match_irq_one |=> !match_irq_one;
	endproperty
	a_irq_one: assert property (p_irq_one) else $error("irq one longer than a cycle");
	property p_irq_two;
		match_irq_two |=> !match_irq_two;
	endproperty
	a_irq_two: assert property (p_irq_two) else $error("irq two longer than a cycle");
	property p_out_read;
		rd_done && paddr == A_OUT |-> prdata[3:2] == 2'b00 && prdata[7:6] == 2'b00 && prdata[31:8] == 24'h0;
	endproperty
	a_out_read: assert property (p_out_read) else $error("set or clear bit read as one");
	property p_mode_read;
		rd_done && paddr == A_MODE |-> prdata[31:3] == 29'h0;
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read has stray bits");
	property p_oe_cause;
		!$stable(p3_oe) |-> $past(dir_wr, 1) || $past(dir_wr, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enables moved without write");
	property p_ready_wait;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule
bind det_timer det_timer_chk det_timer_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .p3_out(p3_out), .p3_oe(p3_oe), .match_irq_one(match_irq_one),
	.match_irq_two(match_irq_two));
`default_nettype wire

//--- det_pins_model.sv
// port 3 pin model: event pulse source and wire levels
`timescale 1ns/10ps
`default_nettype none
module det_pins_model
	import det_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic [1:0] pulse_req,
	input  wire logic [7:0] half_len,
	input  wire logic [7:0] p3_out,
	input  wire logic [7:0] p3_oe,
	output var  logic [7:0] p3_in,
	output var  logic       busy
);
	logic [1:0] sel_q   = 2'b00;
	logic [8:0] cnt_q   = 9'h000;
	logic [1:0] evt_q   = 2'b00;
	logic [7:0] noise_q = 8'h5a;
	assign busy = (cnt_q != 9'h000);
	// one pulse per request, high then low for half_len cycles
	always @(posedge pclk)
	begin
		noise_q <= ~noise_q;
		if (!busy && pulse_req != 2'b00)
		begin
			sel_q <= pulse_req;
			cnt_q <= {half_len, 1'b0};
		end
		else if (busy)
			cnt_q <= cnt_q - 9'h001;
		evt_q <= (busy && cnt_q > {1'b0, half_len}) ? sel_q : 2'b00;
	end
	// driven pins follow design, idle pins wobble, event pins per channel
	always_comb
	begin
		p3_in = (p3_oe & p3_out) | (~p3_oe & noise_q);
		if (!p3_oe[PIN_EVT_ONE])
			p3_in[PIN_EVT_ONE] = evt_q[0];
		if (!p3_oe[PIN_EVT_TWO])
			p3_in[PIN_EVT_TWO] = evt_q[1];
	end
endmodule
`default_nettype wire

//--- test_dual_8bit_interval_event_timer.sv
// self-checking bench for the dual 8-bit timer
`timescale 1ns/10ps
`default_nettype none
module test_dual_8bit_interval_event_timer
	import det_pkg::*;
	;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  p3_in;
	logic [7:0]  p3_out;
	logic [7:0]  p3_oe;
	logic        match_irq_one;
	logic        match_irq_two;
	logic [1:0]  pulse_req = 2'b00;
	logic [7:0]  half_len = 8'h04;
	logic        busy;
	int          miscompares = 0;
	int          check_count = 0;
	int          irq1_n = 0;
	int          irq2_n = 0;
	det_timer det_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
		.match_irq_one(match_irq_one), .match_irq_two(match_irq_two));
	det_pins_model det_pins_model_inst (.pclk(pclk), .pulse_req(pulse_req), .half_len(half_len),
		.p3_out(p3_out), .p3_oe(p3_oe), .p3_in(p3_in), .busy(busy));
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		irq1_n <= irq1_n + int'(match_irq_one === 1'b1);
		irq2_n <= irq2_n + int'(match_irq_two === 1'b1);
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		miscompares++;
		final_report();
	endtask
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0000, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			timeout();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
		chk({31'h0, e}, 32'h0);
	endtask
	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(r, {24'h0, exp});
		chk({31'h0, e}, 32'h0);
	endtask
	task automatic settle();
		repeat (5) @(posedge pclk);
	endtask
	// cycles between two consecutive match pulses of one channel
	task automatic per(input logic ch, output int n);
		int k;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while ((ch ? match_irq_two : match_irq_one) !== 1'b1 && k < 5000);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while ((ch ? match_irq_two : match_irq_one) !== 1'b1 && n < 5000);
		if (k >= 5000 || n >= 5000)
			timeout();
	endtask
	task automatic pulse(input logic [1:0] ch, input logic [7:0] len);
		int n;
		n = 0;
		half_len <= len;
		pulse_req <= ch;
		@(posedge pclk);
		pulse_req <= 2'b00;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (busy === 1'b1 && n < 600);
		if (n >= 600)
			timeout();
		settle();
	endtask
	// reset in mid-run, reset values, unmapped access
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(IDX_MODE, 8'h00);
		rd_chk(IDX_OUT_CTL, 8'h00);
		rd_chk(IDX_P3_DIR, 8'hff);
		rd_chk(IDX_CNT_TWO, 8'h00);
		apb(1'b0, 16'h0100, 8'h00, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask
	task automatic t_wave();
		logic a;
		int   n;
		wr(IDX_P3_DIR, 8'hf9);
		wr(IDX_P3_LATCH, 8'h00);
		settle();
		chk({24'h0, p3_oe}, 32'h06);
		wr(IDX_OUT_CTL, 8'h99);
		settle();
		chk({30'h0, p3_out[2:1]}, 32'h3);
		rd_chk(IDX_OUT_CTL, 8'h11);
		wr(IDX_OUT_CTL, 8'h55);
		settle();
		chk({30'h0, p3_out[2:1]}, 32'h0);
		wr(IDX_OUT_CTL, 8'h00);
		wr(IDX_P3_LATCH, 8'h06);
		settle();
		chk({30'h0, p3_out[2:1]}, 32'h3);
		wr(IDX_P3_LATCH, 8'h00);
		wr(IDX_OUT_CTL, 8'h33);
		wr(IDX_CLK_SEL, 8'h76);
		wr(IDX_CMP_ONE, 8'h03);
		wr(IDX_CMP_TWO, 8'h02);
		rd_chk(IDX_CLK_SEL, 8'h76);
		rd_chk(IDX_CMP_TWO, 8'h02);
		wr(IDX_MODE, 8'h03);
		per(1'b0, n);
		chk(32'(n), 32'd8);
		per(1'b1, n);
		chk(32'(n), 32'd12);
		a = p3_out[1];
		repeat (8) @(posedge pclk);
		chk({31'h0, a ^ p3_out[1]}, 32'h1);
		wr(IDX_MODE, 8'h00);
		wr(IDX_OUT_CTL, 8'h11);
		wr(IDX_MODE, 8'h03);
		per(1'b0, n);
		a = p3_out[1];
		repeat (8) @(posedge pclk);
		chk({31'h0, a ^ p3_out[1]}, 32'h0);
	endtask
	task automatic t_codes();
		int n;
		wr(IDX_MODE, 8'h00);
		wr(IDX_CMP_ONE, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			wr(IDX_MODE, 8'h00);
			wr(IDX_CLK_SEL, 8'(CS_DIV2 + i));
			wr(IDX_MODE, 8'h01);
			per(1'b0, n);
			chk(32'(n), 32'd1 << ((i == 9) ? 11 : i + 1));
		end
		wr(IDX_MODE, 8'h00);
		wr(IDX_CLK_SEL, 8'h02);
		wr(IDX_MODE, 8'h01);
		n = irq1_n;
		repeat (100) @(posedge pclk);
		chk(32'(irq1_n - n), 32'h0);
	endtask
	task automatic t_event();
		int n1;
		int n2;
		t_reset();
		wr(IDX_CLK_SEL, 8'h10);
		wr(IDX_CMP_ONE, 8'h01);
		wr(IDX_CMP_TWO, 8'h00);
		wr(IDX_MODE, 8'h03);
		n1 = irq1_n;
		n2 = irq2_n;
		pulse(2'b01, 8'h04);
		rd_chk(IDX_CNT_ONE, 8'h01);
		pulse(2'b01, 8'h14);
		for (int i = 0; i < 3; i++)
			pulse(2'b10, 8'h04);
		chk(32'(irq1_n - n1), 32'h1);
		chk(32'(irq2_n - n2), 32'h3);
	endtask
	task automatic t_cascade();
		int n;
		wr(IDX_MODE, 8'h00);
		wr(IDX_CLK_SEL, 8'h06);
		wr(IDX_CMP_ONE, 8'h01);
		wr(IDX_CMP_TWO, 8'h01);
		wr(IDX_MODE, 8'h05);
		per(1'b1, n);
		chk(32'(n), 32'd516);
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_wave();
		t_codes();
		t_event();
		t_cascade();
		final_report();
	end
endmodule
`default_nettype wire
